// ===== cr_bus_model.sv
`default_nettype none
module cr_bus_model
(
    input  wire logic                       clk,
    input  wire logic                       ready,
    output var  logic                       valid,
    output var  logic [cr_pkg::FRAME_W-1:0] frame,
    output var  logic                       canRx
);
    timeunit 1ns;
    timeprecision 1ns;
    import cr_pkg::*;
    // Idle bus stays recessive so clear-to-send can build up
    initial
    begin
        valid = 1'h0;
        frame = '0;
        canRx = 1'h1;
    end
    task automatic send(input logic [FRAME_W-1:0] f);
        logic r;
        @(posedge clk) #5;
        valid = 1'h1;
        frame = f;
        r = ready;
        @(posedge clk);
        while (!r)
        begin
            #5 r = ready;
            @(posedge clk);
        end
        #5 valid = 1'h0;
        // Scrambled after release so a stale frame never looks good
        frame = ~f;
    endtask : send
endmodule : cr_bus_model
`default_nettype wire

// ===== cr_can_regs.sv
// Contract
// [R1] Select 0..3 picks id, length/flags/baud, data low, data high; read and write separate.
// [R2] Data words take byte and halfword writes, little-endian, first byte lowest.
// [R3] Software accesses the identifier register only as whole words.
// [R4] Identifier bit 31 set means extended 29-bit, clear means standard 11-bit.
// [R5] Identifier bit 30 marks remote request; such frames carry no payload.
// [R6] Standard frames use bits 10:0 only; bits 28:11 are ignored.
// [R7] Reading the identifier clears receiver flags in bits 4 to 7.
// [R8] Length code in bits 3:0; codes 9 to 15 are invalid.
// [R9] Stuffing error sets bit 4; cleared by identifier read or next start bit.
// [R10] Checksum error sets bit 5; only an identifier read clears it.
// [R11] Frame-available bit 6 sets on a valid frame only.
// [R12] Software reads a frame within 28 bit times of frame-available.
// [R13] Overwrite bit 7 sets when an identifier arrives while frame-available stands.
// [R14] Writing one to bit 8 starts sending; hardware clears it at end or abort.
// [R15] Readback mismatch in identifier phase sets lost bit 9 and aborts.
// [R16] Readback mismatch after identifier phase sets bit error 10 and aborts.
// [R17] Acknowledge bit 11 sets when a receiver acknowledged our frame.
// [R18] Baud field 25:16 gives bit time of field plus one clocks.
// [R19] Software writes the baud field by word or halfword, never byte.
// [R20] Interrupts on frame available, receive errors, and send-request cleared.
// [R21] Receiver muted only after arbitration won; self-reception abort flags nothing.
// [R22] Clear-to-send after 11 recessive bits; pending frame starts at once.
// [R23] Reset clears send request and all flags.
`default_nettype none
module cr_can_regs
(
    input  wire logic                         clk,
    input  wire logic                         rst,
    input  wire logic                         cs,
    input  wire logic [1:0]                   registerSelect,
    input  wire logic [3:0]                   bytesel,
    input  wire logic [cr_pkg::WORD_W-1:0]    d,
    output logic      [cr_pkg::WORD_W-1:0]    q,
    output logic                              irqRx,
    output logic                              irqRxErr,
    output logic                              irqTx,
    input  wire logic                         canRx,
    output logic                              bitTick,
    output logic                              clearToSend,
    output logic                              rxMute,
    input  wire logic                         rxSof,
    input  wire logic                         rxIdDone,
    input  wire logic                         rxStuffErr,
    input  wire logic                         rxCrcErr,
    input  wire logic                         rxFrameValid,
    output logic                              rxFrameReady,
    input  wire logic [cr_pkg::FRAME_W-1:0]   rxFrame,
    output logic                              txStart,
    output logic      [cr_pkg::WORD_W-1:0]    txId,
    output logic      [cr_pkg::DLC_W-1:0]     txDlc,
    output logic      [cr_pkg::DLC_W-1:0]     txByteCount,
    output logic      [cr_pkg::WORD_W-1:0]    txData0,
    output logic      [cr_pkg::WORD_W-1:0]    txData1,
    input  wire logic                         txInIdPhase,
    input  wire logic                         txMismatch,
    input  wire logic                         txAckSeen,
    input  wire logic                         txDone
);
    import cr_pkg::*;

    logic [WORD_W-1:0] rxId, rxData0, rxData1, next_rxId, next_rxData0, next_rxData1;
    logic [DLC_W-1:0]  rxDlc, next_rxDlc;
    logic stuffing_error_flag, crc, frame_available_flag, overwrite_flag, next_stuffing_error_flag, next_crc, next_frame_available_flag, next_overwrite_flag;
    logic rts, lost, bitErr, ack, next_rts, next_lost, next_bitErr, next_ack;
    logic next_txStart, next_rxMute, next_irqRx, next_irqRxErr, next_irqTx;
    cr_tx_state_t      txState, next_txState;
    logic [BAUD_W-1:0] baud, baudCnt, next_baud, next_baudCnt;
    logic [CNT_W-1:0]  recCnt, next_recCnt;
    logic [2:0]        rxSync;
    logic              canRxLevel, next_canRxLevel, next_bitTick, next_cts;
    logic [WORD_W-1:0] next_txId, next_txData0, next_txData1, next_q, lfbRead;
    logic [DLC_W-1:0]  next_txDlc, next_txByteCount;
    logic              rdAccess, wrAccess, idRead, bufValid, drain, tickNow, rxRise;
    logic [FRAME_W-1:0] bufData;
    logic [WORD_W-1:0] inId, inData0, inData1;
    logic [DLC_W-1:0]  inDlc;

    function automatic logic [WORD_W-1:0] mergeLanes(
        input logic [WORD_W-1:0] old,
        input logic [WORD_W-1:0] din,
        input logic [3:0]        lanes
    );
        logic [WORD_W-1:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (lanes[i])
            begin
                res[i*8 +: 8] = din[i*8 +: 8];
            end
        end
        return res;
    endfunction : mergeLanes

    function automatic logic [WORD_W-1:0] maskStdId(input logic [WORD_W-1:0] id);
        logic [WORD_W-1:0] res;
        res = id;
        if (!id[ID_EXT_BIT])
        begin
            res[EXT_ID_W-1:STD_ID_W] = '0;
        end
        return res;
    endfunction : maskStdId

    assign rdAccess = cs && (bytesel == 4'h0);
    assign wrAccess = cs && (bytesel != 4'h0);
    assign idRead   = rdAccess && (registerSelect == RS_ID);
    // Hold completed frames back while the CPU is on the bus so a read is never torn
    assign drain    = bufValid && !cs;
    assign {inId, inDlc, inData0, inData1} = bufData;
    assign tickNow  = (baudCnt == '0);

    cr_frame_buf #(
        .WIDTH (FRAME_W),
        .DEPTH (BUF_DEPTH)
    ) rxBuf (
        .clk      (clk),
        .rst      (rst),
        .inValid  (rxFrameValid),
        .inReady  (rxFrameReady),
        .inData   (rxFrame),
        .outValid (bufValid),
        .outReady (drain),
        .outData  (bufData)
    );

    // Software-written transmit registers
    always_comb
    begin
        next_txId    = txId;
        next_txDlc   = txDlc;
        next_txData0 = txData0;
        next_txData1 = txData1;
        next_baud    = baud;
        if (wrAccess)
        begin
            case (registerSelect)
                RS_ID:  next_txId = maskStdId(d);                              // [R1] [R4] [R6]
                RS_LFB:
                begin
                    if (bytesel[LANE_LFB_LOW])
                    begin
                        next_txDlc = d[DLC_W-1:0];
                    end
                    if (bytesel[LANE_LFB_BAUD])
                    begin
                        next_baud = d[BAUD_LSB +: BAUD_W];                     // [R18]
                    end
                end
                RS_D0:  next_txData0 = mergeLanes(txData0, d, bytesel);        // [R2]
                RS_D1:  next_txData1 = mergeLanes(txData1, d, bytesel);        // [R2]
                default: next_txId = txId;
            endcase
        end
        // Remote frames and invalid codes never send more than the eight stored bytes
        if (next_txId[ID_RTR_BIT])
        begin
            next_txByteCount = '0;                                             // [R5]
        end
        else
        begin
            next_txByteCount = (next_txDlc > DLC_MAX) ? DLC_MAX : next_txDlc; // [R8]
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txId        <= '0;
            txDlc       <= '0;
            txData0     <= '0;
            txData1     <= '0;
            baud        <= BAUD_RESET;
            txByteCount <= '0;
        end
        else
        begin
            txId        <= next_txId;
            txDlc       <= next_txDlc;
            txData0     <= next_txData0;
            txData1     <= next_txData1;
            baud        <= next_baud;
            txByteCount <= next_txByteCount;
        end
    end

    // Receive registers and receiver flags; a setting event wins over a clear
    always_comb
    begin
        next_rxId    = rxId;
        next_rxDlc   = rxDlc;
        next_rxData0 = rxData0;
        next_rxData1 = rxData1;
        next_stuffing_error_flag    = stuffing_error_flag;
        next_crc     = crc;
        next_frame_available_flag   = frame_available_flag;
        next_overwrite_flag    = overwrite_flag;
        if (idRead)
        begin
            next_stuffing_error_flag  = 1'b0;                                                 // [R7]
            next_crc   = 1'b0;                                                 // [R10]
            next_frame_available_flag = 1'b0;
            next_overwrite_flag  = 1'b0;
        end
        if (rxSof)
        begin
            next_stuffing_error_flag = 1'b0;                                                  // [R9]
        end
        // Muted self-reception aborts are expected and flag nothing
        if (rxStuffErr && !rxMute)
        begin
            next_stuffing_error_flag = 1'b1;                                                  // [R9] [R21]
        end
        if (rxCrcErr && !rxMute)
        begin
            next_crc = 1'b1;                                                   // [R10]
        end
        if (rxIdDone && !rxMute && frame_available_flag)
        begin
            next_overwrite_flag = 1'b1;                                                  // [R13]
        end
        if (drain)
        begin
            next_frame_available_flag = 1'b1;                                                 // [R11]
            next_rxId  = maskStdId(inId);                                      // [R4] [R6]
            next_rxDlc = inDlc;                                                // [R8]
            if (!inId[ID_RTR_BIT])
            begin
                next_rxData0 = inData0;                                        // [R5]
                next_rxData1 = inData1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxId    <= '0;
            rxDlc   <= '0;
            rxData0 <= '0;
            rxData1 <= '0;
            stuffing_error_flag    <= 1'b0;                                                   // [R23]
            crc     <= 1'b0;
            frame_available_flag   <= 1'b0;
            overwrite_flag    <= 1'b0;
        end
        else
        begin
            rxId    <= next_rxId;
            rxDlc   <= next_rxDlc;
            rxData0 <= next_rxData0;
            rxData1 <= next_rxData1;
            stuffing_error_flag    <= next_stuffing_error_flag;
            crc     <= next_crc;
            frame_available_flag   <= next_frame_available_flag;
            overwrite_flag    <= next_overwrite_flag;
        end
    end

    // Bus level sampling, bit clock and clear-to-send
    always_comb
    begin
        next_canRxLevel = (rxSync[1] == rxSync[2]) ? rxSync[2] : canRxLevel;
        rxRise          = next_canRxLevel && !canRxLevel && (txState != TX_BUSY);
        next_baudCnt    = (tickNow || rxRise) ? baud : BAUD_W'(baudCnt - 1'b1); // [R18]
        next_bitTick    = tickNow && !rxRise;
        next_recCnt     = recCnt;
        next_cts        = clearToSend;
        if (!canRxLevel)
        begin
            next_recCnt = '0;
            next_cts    = 1'b0;
        end
        else if (next_bitTick && (recCnt != CTS_BITS))
        begin
            next_recCnt = CNT_W'(recCnt + 1'b1);
            next_cts    = (CNT_W'(recCnt + 1'b1) == CTS_BITS);                 // [R22]
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rxSync      <= 3'h7;
            canRxLevel  <= 1'b1;
            baudCnt     <= '0;
            bitTick     <= 1'b0;
            recCnt      <= '0;
            clearToSend <= 1'b0;
        end
        else
        begin
            rxSync      <= {rxSync[1:0], canRx};
            canRxLevel  <= next_canRxLevel;
            baudCnt     <= next_baudCnt;
            bitTick     <= next_bitTick;
            recCnt      <= next_recCnt;
            clearToSend <= next_cts;
        end
    end

    // Transmit sequencing and transmitter flags
    always_comb
    begin
        next_txState = txState;
        next_rts     = rts;
        next_lost    = lost;
        next_bitErr  = bitErr;
        next_ack     = ack;
        next_txStart = 1'b0;
        case (txState)
            TX_IDLE:
            begin
                if (wrAccess && registerSelect == RS_LFB && bytesel[LANE_LFB_RTS] && d[F_RTS])
                begin
                    next_rts     = 1'b1;                                       // [R14]
                    next_lost    = 1'b0;
                    next_bitErr  = 1'b0;
                    next_ack     = 1'b0;
                    next_txState = TX_WAIT;
                end
            end
            TX_WAIT:
            begin
                if (wrAccess && registerSelect == RS_LFB && bytesel[LANE_LFB_RTS] && !d[F_RTS])
                begin
                    next_rts     = 1'b0;
                    next_txState = TX_IDLE;
                end
                else if (next_cts && next_bitTick)
                begin
                    next_txStart = 1'b1;                                       // [R22]
                    next_txState = TX_BUSY;
                end
            end
            TX_BUSY:
            begin
                if (txAckSeen)
                begin
                    next_ack = 1'b1;                                           // [R17]
                end
                if (txMismatch)
                begin
                    next_lost    = txInIdPhase;                                // [R15]
                    next_bitErr  = !txInIdPhase;                               // [R16]
                    next_rts     = 1'b0;                                       // [R14]
                    next_txState = TX_IDLE;
                end
                else if (txDone)
                begin
                    next_rts     = 1'b0;                                       // [R14]
                    next_txState = TX_IDLE;
                end
            end
            default:
            begin
                next_rts     = 1'b0;
                next_txState = TX_IDLE;
            end
        endcase
        next_rxMute   = (next_txState == TX_BUSY) && !txInIdPhase;             // [R21]
        next_irqRx    = next_frame_available_flag;                                            // [R20]
        next_irqRxErr = next_stuffing_error_flag || next_crc;                                 // [R20]
        next_irqTx    = !next_rts;                                             // [R20]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            txState  <= TX_IDLE;
            rts      <= 1'b0;                                                  // [R23]
            lost     <= 1'b0;
            bitErr   <= 1'b0;
            ack      <= 1'b0;
            txStart  <= 1'b0;
            rxMute   <= 1'b0;
            irqRx    <= 1'b0;
            irqRxErr <= 1'b0;
            irqTx    <= 1'b1;
        end
        else
        begin
            txState  <= next_txState;
            rts      <= next_rts;
            lost     <= next_lost;
            bitErr   <= next_bitErr;
            ack      <= next_ack;
            txStart  <= next_txStart;
            rxMute   <= next_rxMute;
            irqRx    <= next_irqRx;
            irqRxErr <= next_irqRxErr;
            irqTx    <= next_irqTx;
        end
    end

    // Read port; the baud field is write-only and reads as zero
    assign lfbRead = {20'h00000, ack, bitErr, lost, rts, overwrite_flag, frame_available_flag, crc, stuffing_error_flag, rxDlc};
    always_comb
    begin
        case (registerSelect)
            RS_ID:   next_q = rxId;                                            // [R1]
            RS_LFB:  next_q = lfbRead;
            RS_D0:   next_q = rxData0;
            RS_D1:   next_q = rxData1;
            default: next_q = '0;
        endcase
        if (!rdAccess)
        begin
            next_q = q;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= next_q;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [BAUD_W:0] sinceTick;
    logic            tickClean;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sinceTick <= '0;
            tickClean <= 1'b0;
        end
        else
        begin
            sinceTick <= bitTick ? '0 : (BAUD_W+1)'(sinceTick + 1'b1);
            tickClean <= (bitTick || tickClean) && !rxRise && (next_baud == baud);
        end
    end

    idReadClear_a: assert property (idRead && !rxIdDone && !rxStuffErr && !rxCrcErr && !drain // [R7]
        |=> !frame_available_flag && !overwrite_flag && !stuffing_error_flag && !crc) else $error("id read left flags set");
    stufSet_a: assert property (rxStuffErr && !rxMute |=> stuffing_error_flag && irqRxErr) // [R9]
        else $error("stuffing error not flagged");
    muteNoFlag_a: assert property (rxMute && rxStuffErr && !stuffing_error_flag |=> !stuffing_error_flag) // [R21]
        else $error("muted abort raised a flag");
    frameAvail_a: assert property ($rose(frame_available_flag) |-> $past(drain)) // [R11]
        else $error("frame available without a valid frame");
    overwrite_a: assert property (rxIdDone && frame_available_flag && !rxMute |=> overwrite_flag) // [R13]
        else $error("overwrite not flagged");
    lostAbort_a: assert property (txState == TX_BUSY && txMismatch && txInIdPhase // [R15]
        |=> lost && !bitErr && !rts && irqTx) else $error("lost arbitration not handled");
    bitErrAbort_a: assert property (txState == TX_BUSY && txMismatch && !txInIdPhase // [R16]
        |=> bitErr && !lost && !rts) else $error("bit error not handled");
    sendDone_a: assert property (txState == TX_BUSY && txDone |=> !rts && irqTx) // [R14]
        else $error("send request not cleared at end");
    baudPeriod_a: assert property (bitTick && tickClean |-> sinceTick == {1'b0, baud}) // [R18]
        else $error("bit time differs from baud plus one");
    startCts_a: assert property (txStart |-> clearToSend && bitTick && rts) // [R22]
        else $error("start without clear to send");

    rxFrame_c: cover property (drain ##[1:20] idRead);
    txWin_c: cover property (txStart ##[1:1000] (txState == TX_BUSY && txDone));
    txLost_c: cover property (txStart ##[1:1000] lost);
    bufFull_c: cover property (!rxFrameReady);
endmodule : cr_can_regs
`default_nettype wire

// ===== cr_can_regs_tb.sv
`default_nettype none
module cr_can_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cr_pkg::*;
    logic clk, rst, cs, irqRx, irqRxErr, irqTx, canRx, txStart, ph, rdPend, rv, rdy;
    logic [1:0]  rsel;
    logic [3:0]  be, txDlc, txCnt;
    logic [6:0]  ev;
    logic [31:0] d, q, txD0, r0, r1, seed;
    logic [FRAME_W-1:0] frm;
    logic [31:0] expQ[$];
    int mismatches, testsRun;
    cr_can_regs dut
    (
        .clk(clk), .rst(rst), .cs(cs), .registerSelect(rsel), .bytesel(be), .d(d), .q(q),
        .irqRx(irqRx), .irqRxErr(irqRxErr), .irqTx(irqTx), .canRx(canRx), .bitTick(),
        .clearToSend(), .rxMute(), .rxSof(ev[0]), .rxIdDone(ev[1]), .rxStuffErr(ev[2]),
        .rxCrcErr(ev[3]), .rxFrameValid(rv), .rxFrameReady(rdy), .rxFrame(frm),
        .txStart(txStart), .txId(), .txDlc(txDlc), .txByteCount(txCnt), .txData0(txD0),
        .txData1(), .txInIdPhase(ph), .txMismatch(ev[4]), .txAckSeen(ev[5]), .txDone(ev[6])
    );
    cr_bus_model bus
    (
        .clk(clk), .ready(rdy), .valid(rv), .frame(frm), .canRx(canRx)
    );
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("Counts: %0d compares, %0d mismatches", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // A read notes its expected value; the monitor takes it a cycle later
    task automatic acc(input logic [1:0] s, input logic [3:0] b, input logic [31:0] v);
        @(posedge clk) #5;
        {cs, rsel, be, d} = {1'h1, s, b, v};
        if (b == 4'h0)
            expQ.push_back(v);
        @(posedge clk) #5;
        cs = 1'h0;
    endtask : acc
    task automatic pul(input logic [6:0] m);
        @(posedge clk) #5 ev = m;
        @(posedge clk) #5 ev = 7'h0;
    endtask : pul
    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #300000 mismatches++;
        tally_and_finish();
    end
    always @(posedge clk)
    begin
        #1;
        if (rdPend)
            chk(q, expQ.pop_front());
        rdPend = cs && be == 4'h0;
    end
    initial
    begin
        seed = 32'h47383BCE;
        rst = 1'h1;
        {cs, rsel, be, d, ev, ph, rdPend} = '0;
        repeat (5) @(posedge clk);
        #5 rst = 1'h0;
        chk(32'(irqTx), 32'h1);
        acc(2'h1, 4'h0, 32'h0);
        // Lost, bit error, then acknowledge; each new request wipes the old flags
        for (int i = 0; i < 3; i++)
        begin
            acc(2'h1, 4'h2, 32'h100);
            acc(2'h1, 4'h0, 32'h100);
            for (int n = 0; n < 400 && !txStart; n++) @(posedge clk) #1;
            chk(32'(txStart), 32'h1);
            ph = i == 0;
            if (i == 2) pul(7'h20);
            pul(i < 2 ? 7'h10 : 7'h40);
            acc(2'h1, 4'h0, 32'h200 << i);
            chk(32'(irqTx), 32'h1);
        end
        $display("transmit test done");
        acc(2'h0, 4'hF, 32'h40000123);
        acc(2'h1, 4'hC, 32'h00130000);
        acc(2'h1, 4'h1, 32'h8);
        repeat (2) @(posedge clk);
        chk(32'(txCnt), 32'h0);
        acc(2'h0, 4'hF, 32'h123);
        acc(2'h1, 4'h1, 32'hF);
        repeat (2) @(posedge clk);
        chk(32'(txDlc), 32'hF);
        chk(32'(txCnt), 32'h8);
        acc(2'h2, 4'hF, 32'h11223344);
        acc(2'h2, 4'h1, 32'hAA);
        chk(txD0, 32'h112233AA);
        $display("write test done");
        r0 = rnd();
        r1 = rnd();
        bus.send({32'h80ABCDEF, 4'h8, r0, r1});
        repeat (3) @(posedge clk);
        pul(7'h2);
        acc(2'h1, 4'h0, 32'h8C8);
        chk(32'(irqRx), 32'h1);
        acc(2'h0, 4'h0, 32'h80ABCDEF);
        acc(2'h1, 4'h0, 32'h808);
        acc(2'h2, 4'h0, r0);
        acc(2'h3, 4'h0, r1);
        bus.send({32'h5FFFFFFF, 4'h8, r1, r0});
        repeat (3) @(posedge clk);
        acc(2'h0, 4'h0, 32'h400007FF);
        acc(2'h2, 4'h0, r0);
        pul(7'hC);
        acc(2'h1, 4'h0, 32'h838);
        chk(32'(irqRxErr), 32'h1);
        pul(7'h1);
        acc(2'h1, 4'h0, 32'h828);
        acc(2'h0, 4'h0, 32'h400007FF);
        acc(2'h1, 4'h0, 32'h808);
        $display("receive test done");
        // Writes keep chip select up, which stalls the drain and fills the buffer
        @(posedge clk) #5 {cs, rsel, be, d} = {1'h1, 2'h3, 4'hF, rnd()};
        bus.send({32'h123, 4'h8, r0, r1});
        bus.send({32'h80000456, 4'h8, r1, r0});
        @(posedge clk) #1;
        chk(32'(rdy), 32'h0);
        #4 cs = 1'h0;
        repeat (6) @(posedge clk);
        chk(32'(rdy), 32'h1);
        acc(2'h0, 4'h0, 32'h80000456);
        repeat (2) @(posedge clk);
        $display("buffer test done");
        tally_and_finish();
    end
endmodule : cr_can_regs_tb
`default_nettype wire

// ===== cr_frame_buf.sv
`default_nettype none
module cr_frame_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
)
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wrPtr;
    logic [PTR_W-1:0] rdPtr;
    logic [CNT_W-1:0] count;
    logic [PTR_W-1:0] next_wrPtr;
    logic [PTR_W-1:0] next_rdPtr;
    logic [CNT_W-1:0] next_count;
    logic             push;
    logic             pop;

    assign inReady  = (count != FULL_CNT);
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb
    begin
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        if (push)
        begin
            next_wrPtr = (wrPtr == LAST_PTR) ? '0 : PTR_W'(wrPtr + 1'b1);
        end
        if (pop)
        begin
            next_rdPtr = (rdPtr == LAST_PTR) ? '0 : PTR_W'(rdPtr + 1'b1);
        end
        if (push && !pop)
        begin
            next_count = CNT_W'(count + 1'b1);
        end
        else if (pop && !push)
        begin
            next_count = CNT_W'(count - 1'b1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // Storage needs no reset; occupancy guards every read
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wrPtr] <= inData;
        end
    end
endmodule : cr_frame_buf
`default_nettype wire

// ===== cr_pkg.sv
`default_nettype none
package cr_pkg;
    localparam int WORD_W = 32;
    localparam int DLC_W  = 4;
    localparam int BAUD_W = 10;
    localparam int CNT_W  = 4;

    localparam logic [1:0] RS_ID  = 2'h0;
    localparam logic [1:0] RS_LFB = 2'h1;
    localparam logic [1:0] RS_D0  = 2'h2;
    localparam logic [1:0] RS_D1  = 2'h3;

    localparam int ID_EXT_BIT = 31;
    localparam int ID_RTR_BIT = 30;
    localparam int STD_ID_W   = 11;
    localparam int EXT_ID_W   = 29;

    localparam int F_RTS    = 8;
    localparam int BAUD_LSB = 16;
    localparam int LANE_LFB_LOW  = 0;
    localparam int LANE_LFB_RTS  = 1;
    localparam int LANE_LFB_BAUD = 2;

    localparam logic [DLC_W-1:0]  DLC_MAX    = 4'h8;
    localparam logic [BAUD_W-1:0] BAUD_RESET = 10'h013;
    localparam logic [CNT_W-1:0]  CTS_BITS   = 4'hB;

    localparam int FRAME_W = WORD_W + DLC_W + 2 * WORD_W;
    localparam int BUF_DEPTH = 2;

    typedef enum logic [2:0]
    {
        TX_IDLE = 3'h1,
        TX_WAIT = 3'h2,
        TX_BUSY = 3'h4
    } cr_tx_state_t;
endpackage : cr_pkg
`default_nettype wire
